//--- design/sasc_pkg.sv
// Contract
// - attenuation travels as a five-bit serial word, one bit per step.
// - top bit selects 8 dB, bottom bit selects 0.5 dB.
// - at power-up the five bits load from the five parallel inputs.
// - any of 32 settings may be the power-up state until first word.
// - serial data sampled on serial clock rising edge, one bit per cycle.
package sasc_pkg;

	localparam int ATTEN_BITS = 5;
	localparam int MARKER_POS = 5;
	localparam int SHIFT_BITS = 6;

	// word bit positions by weight
	localparam int POS_8DB    = 4;
	localparam int POS_4DB    = 3;
	localparam int POS_2DB    = 2;
	localparam int POS_1DB    = 1;
	localparam int POS_HALFDB = 0;

	// register map
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_ATTEN  = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;

	localparam logic [4:0] ATTEN_RST  = 5'h00;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// serial link timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int MIN_STROBE_NS = 30;
	// whole samples that a minimum-width strobe always spans
	localparam int MIN_STROBE_CYC = (MIN_STROBE_NS * 1000) / CLK_PERIOD_PS;

	typedef struct packed {
		logic       weight8dbBit;
		logic       weight4dbBit;
		logic       weight2dbBit;
		logic       weight1dbBit;
		logic       weightHalfDbBit;
	} sasc_atten_type;

	typedef struct packed {
		logic sck;
		logic sdi;
		logic wordStrobe;
	} sasc_link_type;

endpackage

//--- design/sasc_step_atten_serial_ctrl.sv
`timescale 1ns/1ps
module sasc_step_atten_serial_ctrl #(
	parameter int STROBE_CYC = sasc_pkg::MIN_STROBE_CYC
) (
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    arst_n,
	// serial link from host
	input  wire logic                    serialClk,
	input  wire logic                    serialData,
	input  wire logic                    wordStrobe,
	// power-up setting straps
	input  wire logic [4:0]              powerupPins,
	// axi4-lite write address
	input  wire logic [3:0]              awaddr,
	input  wire logic                    awvalid,
	output logic                         awready,
	// axi4-lite write data
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output logic                         wready,
	// axi4-lite write response
	output logic [1:0]                   bresp,
	output logic                         bvalid,
	input  wire logic                    bready,
	// axi4-lite read address
	input  wire logic [3:0]              araddr,
	input  wire logic                    arvalid,
	output logic                         arready,
	// axi4-lite read data
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	output logic                         rvalid,
	input  wire logic                    rready,
	// applied attenuation and marker error flag
	output sasc_pkg::sasc_atten_type     atten,
	output logic                         markerError
);

	if (STROBE_CYC < 1 || STROBE_CYC > 255) begin : gStrobeRange
		$error("STROBE_CYC must lie between 1 and 255");
	end

	// two-stage synchronisers for link pins and straps
	sasc_pkg::sasc_link_type linkMeta_q, linkSync_q, linkPrev_q, linkMeta_d, linkSync_d, linkPrev_d;
	logic [4:0] strapMeta_q, strapSync_q, strapMeta_d, strapSync_d;

	always_comb begin
		linkMeta_d = '{sck: serialClk, sdi: serialData, wordStrobe: wordStrobe};
		linkSync_d = linkMeta_q;
		linkPrev_d = linkSync_q;
		strapMeta_d = powerupPins;
		strapSync_d = strapMeta_q;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			linkMeta_q  <= '0;
			linkSync_q  <= '0;
			linkPrev_q  <= '0;
		end else begin
			linkMeta_q  <= linkMeta_d;
			linkSync_q  <= linkSync_d;
			linkPrev_q  <= linkPrev_d;
		end
	end

	// straps keep sampling through reset so boot reads settled levels
	always_ff @(posedge mclk) begin
		strapMeta_q <= strapMeta_d;
		strapSync_q <= strapSync_d;
	end

	// edges come from the synchronised copy against the one behind it
	logic sckRise, strobeHigh;
	assign sckRise    = linkSync_q.sck && !linkPrev_q.sck;
	assign strobeHigh = linkSync_q.wordStrobe;

	// serial shifter, strobe filter, applied setting
	typedef enum logic [1:0] {
		SASC_BOOT0 = 2'h0,
		SASC_BOOT1 = 2'h1,
		SASC_RUN   = 2'h3
	} sasc_boot_type;

	sasc_boot_type bootState_q, bootState_d;
	logic [sasc_pkg::SHIFT_BITS-1:0] shift_q, shift_d;
	logic [7:0] strobeCnt_q, strobeCnt_d;
	logic strobeDone_q, strobeDone_d;
	sasc_pkg::sasc_atten_type atten_q, atten_d;
	logic markerErr_q, markerErr_d;
	logic [7:0] wordCount_q, wordCount_d;
	logic swLoad;
	logic [4:0] swValue;
	logic swClrErr;

	// map a raw five-bit word onto the weighted setting bits
	function automatic sasc_pkg::sasc_atten_type toAtten(input logic [4:0] w);
		sasc_pkg::sasc_atten_type a;
		a.weight8dbBit    = w[sasc_pkg::POS_8DB];
		a.weight4dbBit    = w[sasc_pkg::POS_4DB];
		a.weight2dbBit    = w[sasc_pkg::POS_2DB];
		a.weight1dbBit    = w[sasc_pkg::POS_1DB];
		a.weightHalfDbBit = w[sasc_pkg::POS_HALFDB];
		return a;
	endfunction

	always_comb begin
		bootState_d  = bootState_q;
		strobeCnt_d  = strobeCnt_q;
		strobeDone_d = strobeDone_q;
		atten_d      = atten_q;
		// a set in the same cycle as a clear wins
		markerErr_d  = markerErr_q && !swClrErr;
		wordCount_d  = wordCount_q;
		case (bootState_q)
			SASC_BOOT0: bootState_d = SASC_BOOT1;
			SASC_BOOT1: begin
				// straps are taken once, two edges after reset lets go
				atten_d     = toAtten(strapSync_q);
				bootState_d = SASC_RUN;
			end
			SASC_RUN: begin
				// strobe must be seen STROBE_CYC samples in a row; one apply per pulse
				if (!strobeHigh) begin
					strobeCnt_d  = 8'h00;
					strobeDone_d = 1'b0;
				end else if (!strobeDone_q) begin
					if (strobeCnt_q >= 8'(STROBE_CYC - 1)) begin
						strobeDone_d = 1'b1;
						atten_d      = toAtten(shift_q[sasc_pkg::ATTEN_BITS-1:0]);
						wordCount_d  = wordCount_q + 8'h01;
						if (shift_q[sasc_pkg::MARKER_POS])
							markerErr_d = 1'b1;
					end else begin
						strobeCnt_d = strobeCnt_q + 8'h01;
					end
				end
				// a bus write in the same cycle as a strobe apply overrides it
				if (swLoad)
					atten_d = toAtten(swValue);
			end
			default: bootState_d = SASC_BOOT0;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bootState_q  <= SASC_BOOT0;
			strobeCnt_q  <= 8'h00;
			strobeDone_q <= 1'b0;
			atten_q      <= sasc_pkg::ATTEN_RST;
			markerErr_q  <= 1'b0;
			wordCount_q  <= 8'h00;
		end else begin
			bootState_q  <= bootState_d;
			strobeCnt_q  <= strobeCnt_d;
			strobeDone_q <= strobeDone_d;
			atten_q      <= atten_d;
			markerErr_q  <= markerErr_d;
			wordCount_q  <= wordCount_d;
		end
	end

	// serial shifter keeps the last SHIFT_BITS bits, marker first
	always_comb begin
		shift_d = shift_q;
		if (bootState_q == SASC_RUN && sckRise)
			shift_d = {shift_q[sasc_pkg::SHIFT_BITS-2:0], linkSync_q.sdi};
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			shift_q <= '0;
		else
			shift_q <= shift_d;
	end

	assign atten       = atten_q;
	assign markerError = markerErr_q;

	// axi4-lite slave
	logic [3:0]  awAddr_q, awAddr_d;
	logic        awHave_q, awHave_d, wHave_q, wHave_d;
	logic [31:0] wData_q, wData_d;
	logic        wByte0_q, wByte0_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        doWrite;

	function automatic logic isMapped(input logic [3:0] addr);
		return addr == sasc_pkg::OFF_CTRL || addr == sasc_pkg::OFF_ATTEN || addr == sasc_pkg::OFF_STATUS;
	endfunction

	// the response waits until address and data are both held
	assign doWrite  = awHave_q && wHave_q && !bvalid_q;
	assign swLoad   = doWrite && wByte0_q && awAddr_q == sasc_pkg::OFF_ATTEN;
	assign swValue  = wData_q[4:0];
	assign swClrErr = doWrite && wByte0_q && awAddr_q == sasc_pkg::OFF_STATUS && wData_q[0];

	always_comb begin
		awAddr_d = awAddr_q;
		awHave_d = awHave_q;
		wHave_d  = wHave_q;
		wData_d  = wData_q;
		wByte0_d = wByte0_q;
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		// each channel is taken only at an edge with valid and ready both high
		if (awvalid && awready) begin
			awAddr_d = awaddr;
			awHave_d = 1'b1;
		end
		if (wvalid && wready) begin
			wData_d  = wdata;
			wByte0_d = wstrb[0];
			wHave_d  = 1'b1;
		end
		if (doWrite) begin
			bvalid_d = 1'b1;
			bresp_d  = isMapped(awAddr_q) ? sasc_pkg::RESP_OKAY : sasc_pkg::RESP_SLVERR;
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
			awHave_d = 1'b0;
			wHave_d  = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rresp_d  = isMapped(araddr) ? sasc_pkg::RESP_OKAY : sasc_pkg::RESP_SLVERR;
			case (araddr)
				sasc_pkg::OFF_CTRL:   rdata_d = {24'h000000, wordCount_q};
				sasc_pkg::OFF_ATTEN:  rdata_d = {27'h0000000, atten_q};
				sasc_pkg::OFF_STATUS: rdata_d = {25'h0000000, shift_q, markerErr_q};
				default:              rdata_d = 32'h00000000;
			endcase
		end else if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awAddr_q <= 4'h0;
			awHave_q <= 1'b0;
			wHave_q  <= 1'b0;
			wData_q  <= 32'h00000000;
			wByte0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q  <= 2'h0;
			rdata_q  <= 32'h00000000;
		end else begin
			awAddr_q <= awAddr_d;
			awHave_q <= awHave_d;
			wHave_q  <= wHave_d;
			wData_q  <= wData_d;
			wByte0_q <= wByte0_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
		end
	end

	// readies register the inverse of the next capture flags (of next rvalid for arready), so each output is a plain flop
	logic awReady_q, awReady_d, wReady_q, wReady_d, arReady_q, arReady_d;

	always_comb begin
		awReady_d = !awHave_d;
		wReady_d  = !wHave_d;
		arReady_d = !rvalid_d;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awReady_q <= 1'b0;
			wReady_q  <= 1'b0;
			arReady_q <= 1'b0;
		end else begin
			awReady_q <= awReady_d;
			wReady_q  <= wReady_d;
			arReady_q <= arReady_d;
		end
	end

	assign awready = awReady_q;
	assign wready  = wReady_q;
	assign arready = arReady_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;

endmodule

//--- tb/sasc_checker.sv
`timescale 1ns/1ps
module sasc_checker #(
	parameter int STROBE_CYC = 4
) (
	// clock and reset
	input wire logic                     mclk,
	input wire logic                     arst_n,
	// link and straps
	input wire logic                     serialClk,
	input wire logic                     serialData,
	input wire logic                     wordStrobe,
	input wire logic [4:0]               powerupPins,
	// bus write data and outputs
	input wire logic                     wvalid,
	input wire logic                     wready,
	input wire sasc_pkg::sasc_atten_type atten,
	input wire logic                     markerError
);
	localparam int APPLY_MAX = STROBE_CYC + 8;
	logic       sckPrev_q, sckPrev_d;
	logic [5:0] shift_q, shift_d;
	logic [7:0] quiet_q, quiet_d;
	// shadow shift register and cycles since the last cause of a setting change
	always_comb begin
		sckPrev_d = serialClk;
		shift_d   = (serialClk && !sckPrev_q) ? {shift_q[4:0], serialData} : shift_q;
		quiet_d   = (wordStrobe || (wvalid && wready)) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hFF};
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sckPrev_q <= 1'b0;
			shift_q   <= 6'h00;
			quiet_q   <= 8'h00;
		end else begin
			sckPrev_q <= sckPrev_d;
			shift_q   <= shift_d;
			quiet_q   <= quiet_d;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	AST_POWERUP_LOAD: assert property ($rose(arst_n) |-> ##[1:4] atten == powerupPins)
		else $error("power-up setting differs from straps");
	AST_WORD_APPLY: assert property ($rose(wordStrobe) |-> ##[1:APPLY_MAX] atten == shift_q[4:0])
		else $error("strobed word not applied");
	AST_WEIGHT_ORDER: assert property ($rose(wordStrobe) |-> ##[1:APPLY_MAX]
		atten.weight8dbBit == shift_q[4] && atten.weight1dbBit == shift_q[1] && atten.weightHalfDbBit == shift_q[0])
		else $error("weight bits misplaced");
	AST_HOLD: assert property (!$stable(atten) |-> quiet_q < 8'h10)
		else $error("setting changed without cause");
	AST_NO_EARLY: assert property ($rose(wordStrobe) |-> ##1 $stable(atten) [*3])
		else $error("setting changed too soon after strobe");
	AST_MARKER: assert property ($rose(markerError) |-> shift_q[5])
		else $error("marker flag without marker bit");
	COV_MARKER: cover property ($rose(markerError));
	COV_STRAPS: cover property ($rose(arst_n) ##2 atten == 5'h1F);
	COV_APPLY: cover property ($rose(wordStrobe) ##[1:APPLY_MAX] !$stable(atten));
endmodule
bind sasc_step_atten_serial_ctrl sasc_checker #(.STROBE_CYC(STROBE_CYC)) sasc_checker_inst (.mclk(mclk),
	.arst_n(arst_n), .serialClk(serialClk), .serialData(serialData), .wordStrobe(wordStrobe),
	.powerupPins(powerupPins), .wvalid(wvalid), .wready(wready), .atten(atten), .markerError(markerError));

//--- tb/sasc_host_model.sv
`timescale 1ns/1ps
module sasc_host_model (
	// serial link to the attenuator
	output logic serialClk,
	output logic serialData,
	output logic wordStrobe
);
	initial begin
		serialClk  = 1'b0;
		serialData = 1'b0;
		wordStrobe = 1'b0;
	end
	// marker first; data flips after its hold so no stale level lingers
	task automatic send_word(input logic [5:0] word, input int nBits, input logic doStrobe);
		// start off the bench clock edge so no pin moves at a sampling edge
		#0.5;
		for (int i = nBits - 1; i >= 0; i--) begin
			serialData = word[i];
			#52.5 serialClk = 1'b1;
			#62.5 serialClk = 1'b0;
			#10 serialData = ~serialData;
		end
		if (doStrobe) begin
			#20 wordStrobe = 1'b1;
			#48 wordStrobe = 1'b0;
		end
	endtask
endmodule

//--- tb/sasc_step_atten_serial_ctrl_bench.sv
`timescale 1ns/1ps
`define SASC_CHECK(got, exp) begin numChecks++; if ((got) !== (exp)) begin failures++; \
	$display("unexpected at %0t got %0h expected %0h", $time, got, exp); end end
module sasc_step_atten_serial_ctrl_bench;
	logic                     mclk, arst_n, serialClk, serialData, wordStrobe, markerError;
	logic                     awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0]               bresp, rresp, rdResp;
	logic [3:0]               awaddr, araddr, wstrb;
	logic [4:0]               powerupPins, expAtten;
	logic [31:0]              wdata, rdata, rdVal, lfsr;
	sasc_pkg::sasc_atten_type atten;
	int                       failures, numChecks, cycles, applied;
	sasc_host_model sasc_host_model_inst (.serialClk(serialClk), .serialData(serialData), .wordStrobe(wordStrobe));
	sasc_step_atten_serial_ctrl sasc_step_atten_serial_ctrl_inst (.mclk(mclk), .arst_n(arst_n),
		.serialClk(serialClk), .serialData(serialData), .wordStrobe(wordStrobe), .powerupPins(powerupPins),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .atten(atten),
		.markerError(markerError));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic axi_write(input logic [3:0] addr, input logic [31:0] data);
		awaddr  <= addr;
		wdata   <= data;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rdResp = bresp;
		@(posedge mclk);
	endtask
	task automatic axi_read(input logic [3:0] addr);
		araddr  <= addr;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rdVal  = rdata;
		rdResp = rresp;
		@(posedge mclk);
	endtask
	task automatic do_reset(input logic [4:0] pins);
		arst_n      <= 1'b0;
		powerupPins <= pins;
		applied     = 0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		`SASC_CHECK(atten, pins)
	endtask
	task automatic apply_word(input logic [5:0] w);
		sasc_host_model_inst.send_word(w, 6, 1'b1);
		applied++;
		expAtten = w[4:0];
		repeat (16) @(posedge mclk);
		`SASC_CHECK(atten, expAtten)
		axi_read(sasc_pkg::OFF_ATTEN);
		`SASC_CHECK(rdVal, {27'h0, expAtten})
	endtask
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		arst_n      = 1'b0;
		powerupPins = 5'h00;
		wstrb       = 4'hF;
		{failures, numChecks, cycles} = '0;
		lfsr = 32'h873C8107;
		do_reset(5'h00);
		do_reset(5'h1F);
		lfsr = next_rand(lfsr);
		do_reset(lfsr[4:0]);
		for (int i = 0; i < 5; i++) apply_word(6'h01 << i);
		for (int i = 0; i < 6; i++) begin
			lfsr = next_rand(lfsr);
			apply_word({1'b0, lfsr[4:0]});
		end
		sasc_host_model_inst.send_word(6'h15, 3, 1'b0);
		repeat (16) @(posedge mclk);
		`SASC_CHECK(atten, expAtten)
		apply_word(6'h0A);
		apply_word(6'h23);
		`SASC_CHECK(markerError, 1'b1)
		axi_write(sasc_pkg::OFF_STATUS, 32'h1);
		axi_read(sasc_pkg::OFF_STATUS);
		`SASC_CHECK(rdVal, 32'h46)
		axi_read(sasc_pkg::OFF_CTRL);
		`SASC_CHECK(rdVal, 32'(applied))
		axi_read(4'hC);
		`SASC_CHECK({rdResp, rdVal}, {sasc_pkg::RESP_SLVERR, 32'h0})
		axi_write(sasc_pkg::OFF_ATTEN, {27'h0, lfsr[9:5]});
		repeat (2) @(posedge mclk);
		`SASC_CHECK({rdResp, atten}, {sasc_pkg::RESP_OKAY, lfsr[9:5]})
		wstrb <= 4'h0;
		axi_write(sasc_pkg::OFF_ATTEN, {27'h0, ~lfsr[9:5]});
		wstrb <= 4'hF;
		`SASC_CHECK({rdResp, atten}, {sasc_pkg::RESP_OKAY, lfsr[9:5]})
		axi_write(4'hC, 32'h0);
		`SASC_CHECK(rdResp, sasc_pkg::RESP_SLVERR)
		`SASC_CHECK(markerError, 1'b0)
		do_reset(lfsr[14:10]);
		apply_word(6'h11);
		report_and_stop();
	end
endmodule
